// file: rtl/motor_starter_control.sv
// control logic for overload relay, direct starter and reversing starter
// assumes fieldbus command bytes and digital inputs are synchronous to clock
//
// What this block does
// - overload mode reports warnings, fault, inputs
// - overload command: fault reset, prepare emergency
// - byte1 drives relay two, dc output
// - direct mode switches contactor on relay zero
// - direct mode: input four start, five stop
// - checkback samples input zero when enabled
// - direct mode fault output selectable
// - direct mode monitoring byte zero layout
// - reversing: relay zero forward, one reverse
// - reversing: inputs three/four start, five stops
// - reversing mode fault output selectable
// - opposite direction needs off and lockout
// - same direction restarts without lockout wait
// - overload mode: relay zero closed until fault
`timescale 1ns/100ps
module motor_starter_control
#(
   parameter int unsigned TICK_CYCLES  = motor_starter_pkg::TICK_CYCLES,
   parameter int unsigned CHECKBACK_MS = motor_starter_pkg::CHECKBACK_MS
)
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // configuration
   input  wire logic [1:0]  ctrl_mode,
   input  wire logic [1:0]  fault_out_sel,
   input  wire logic        local_start_en,
   input  wire logic        checkback_en,
   input  wire logic [15:0] reverse_lockout_ms,
   // fieldbus cyclic data
   input  wire logic [7:0]  cmd_byte0,
   input  wire logic [7:0]  cmd_byte1,
   output logic      [7:0]  mon_byte0,
   output logic      [7:0]  mon_byte1,
   // protection status
   input  wire logic        overload_trip,
   input  wire logic        overload_warn,
   // field pins
   input  wire logic [5:0]  digital_in,
   output logic             relay_out_zero,
   output logic             relay_out_one,
   output logic             relay_out_two,
   output logic             dc_supply_output,
   output logic             emerg_start_prep
);

   motor_starter_pkg::run_state_t state_ff;
   motor_starter_pkg::run_state_t nxt_state;
   motor_starter_pkg::run_state_t last_dir_ff;
   logic        fault_ff;
   logic [7:0]  cmd0_prev_ff;
   logic [5:0]  din_prev_ff;
   logic [15:0] cb_cnt_ff;
   logic        off_pulse;
   logic        ms_tick;
   logic        lockout_busy;
   logic        is_ovl;
   logic        is_dir;
   logic        is_rev;
   logic        auto_mode;
   logic        req_fwd;
   logic        req_rev;
   logic        req_off;
   logic        reset_edge;
   logic        cb_mismatch;
   logic        cb_fault;
   logic        fault_on_r2;
   logic        fault_on_dc;

   initial
   begin
      if (TICK_CYCLES < 1 || CHECKBACK_MS < 1 || CHECKBACK_MS > 65535)
         $error("motor_starter_control: unsupported parameters");
   end

   assign is_ovl    = (ctrl_mode == motor_starter_pkg::overload_relay_mode);
   assign is_dir    = (ctrl_mode == motor_starter_pkg::direct_starter_mode);
   assign is_rev    = (ctrl_mode == motor_starter_pkg::reversing_starter_mode);
   assign auto_mode = cmd_byte0[motor_starter_pkg::CMD0_AUTO_MODE];

   // edge history for commands and local push buttons
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         cmd0_prev_ff <= 8'h00;
         din_prev_ff  <= 6'h00;
      end
      else
      begin
         cmd0_prev_ff <= cmd_byte0;
         din_prev_ff  <= digital_in;
      end
   end

   // bus commands act in auto mode, local buttons when enabled and not in auto
   always_comb
   begin
      req_fwd = 1'b0;
      req_rev = 1'b0;
      req_off = 1'b0;
      if (is_dir || is_rev)
      begin
         if (auto_mode)
         begin
            req_fwd = cmd_byte0[motor_starter_pkg::CMD0_RUN_FWD]
                      & ~cmd0_prev_ff[motor_starter_pkg::CMD0_RUN_FWD];
            req_rev = is_rev & cmd_byte0[motor_starter_pkg::CMD0_RUN_REV]
                      & ~cmd0_prev_ff[motor_starter_pkg::CMD0_RUN_REV];
            req_off = cmd_byte0[motor_starter_pkg::CMD0_OFF];
         end
         else if (local_start_en)
         begin
            req_fwd = digital_in[4] & ~din_prev_ff[4];
            req_rev = is_rev & digital_in[3] & ~din_prev_ff[3];
            req_off = digital_in[5];
         end
      end
   end

   // contactor checkback: feedback must follow the run state within the window
   assign cb_mismatch = checkback_en & (is_dir | is_rev)
                        & (digital_in[0] != (state_ff != motor_starter_pkg::motor_off));

   always_ff @(posedge clock)
   begin
      if (sys_rst || !cb_mismatch)
         cb_cnt_ff <= 16'h0;
      else if (ms_tick && !cb_fault)
         cb_cnt_ff <= cb_cnt_ff + 16'h1;
   end

   assign cb_fault = (cb_cnt_ff == 16'(CHECKBACK_MS));

   // latched summary fault; a new cause beats a simultaneous reset
   assign reset_edge = cmd_byte0[motor_starter_pkg::CMD0_FAULT_RESET]
                       & ~cmd0_prev_ff[motor_starter_pkg::CMD0_FAULT_RESET];

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         fault_ff <= 1'b0;
      else if (overload_trip || cb_fault)
         fault_ff <= 1'b1;
      else if (reset_edge)
         fault_ff <= 1'b0;
   end

   // run state; opposite direction only from off with lockout expired
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         motor_starter_pkg::motor_off:
         begin
            if (req_off)
               nxt_state = state_ff;
            else if (req_fwd && (last_dir_ff == motor_starter_pkg::run_fwd
                                 || !lockout_busy))
               nxt_state = motor_starter_pkg::run_fwd;
            else if (req_rev && (last_dir_ff == motor_starter_pkg::run_rev
                                 || !lockout_busy))
               nxt_state = motor_starter_pkg::run_rev;
         end
         default:
         begin
            if (req_off)
               nxt_state = motor_starter_pkg::motor_off;
         end
      endcase
      // a fault, overload mode, unused mode code or reverse run in direct mode drops the contactors at once
      if (fault_ff || overload_trip || cb_fault || !(is_dir || is_rev)
          || (is_dir && state_ff == motor_starter_pkg::run_rev))
         nxt_state = motor_starter_pkg::motor_off;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         state_ff <= motor_starter_pkg::motor_off;
      else
         state_ff <= nxt_state;
   end

   // remember direction so a same-way restart skips the lockout
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         last_dir_ff <= motor_starter_pkg::motor_off;
      else if (nxt_state != motor_starter_pkg::motor_off)
         last_dir_ff <= nxt_state;
   end

   assign off_pulse = (state_ff != motor_starter_pkg::motor_off)
                      && (nxt_state == motor_starter_pkg::motor_off);

   reverse_lockout_timer
   #(
      .TICK_CYCLES (TICK_CYCLES),
      .LOCK_WIDTH  (motor_starter_pkg::LOCKOUT_WIDTH)
   )
   u_lockout
   (
      .clock        (clock),
      .sys_rst      (sys_rst),
      .off_pulse    (off_pulse),
      .lockout_ms   (reverse_lockout_ms),
      .ms_tick      (ms_tick),
      .lockout_busy (lockout_busy)
   );

   assign fault_on_r2 = (fault_out_sel == motor_starter_pkg::fault_out_relay_two);
   assign fault_on_dc = (fault_out_sel == motor_starter_pkg::fault_out_dc_supply);

   // relay drivers; forward and reverse come from one state so never overlap
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         relay_out_zero   <= motor_starter_pkg::RELAY_RESET;
         relay_out_one    <= motor_starter_pkg::RELAY_RESET;
         relay_out_two    <= motor_starter_pkg::RELAY_RESET;
         dc_supply_output <= motor_starter_pkg::RELAY_RESET;
         emerg_start_prep <= 1'b0;
      end
      else
      begin
         if (is_ovl)
         begin
            relay_out_zero <= ~fault_ff;
            relay_out_one  <= fault_ff;
         end
         else
         begin
            relay_out_zero <= (nxt_state == motor_starter_pkg::run_fwd);
            relay_out_one  <= is_rev ? (nxt_state == motor_starter_pkg::run_rev)
                              : cmd_byte1[motor_starter_pkg::CMD1_RELAY_ONE];
         end
         relay_out_two    <= fault_on_r2 ? fault_ff
                             : cmd_byte1[motor_starter_pkg::CMD1_RELAY_TWO];
         dc_supply_output <= fault_on_dc ? fault_ff
                             : cmd_byte1[motor_starter_pkg::CMD1_DC_SUPPLY];
         emerg_start_prep <= cmd_byte0[motor_starter_pkg::CMD0_PREP_EMERG];
      end
   end

   // cyclic monitoring bytes
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         mon_byte0 <= motor_starter_pkg::MON_RESET;
         mon_byte1 <= motor_starter_pkg::MON_RESET;
      end
      else
      begin
         mon_byte0 <= 8'h00;
         mon_byte0[motor_starter_pkg::MON0_SUM_WARN]  <= overload_warn;
         mon_byte0[motor_starter_pkg::MON0_SUM_FAULT] <= fault_ff;
         mon_byte0[motor_starter_pkg::MON0_OVL_WARN]  <= overload_warn;
         if (!is_ovl)
         begin
            mon_byte0[motor_starter_pkg::MON0_LOCAL]   <= ~auto_mode;
            mon_byte0[motor_starter_pkg::MON0_RUN_FWD] <=
               (state_ff == motor_starter_pkg::run_fwd);
            mon_byte0[motor_starter_pkg::MON0_OFF]     <=
               (state_ff == motor_starter_pkg::motor_off);
         end
         if (is_rev)
         begin
            mon_byte0[motor_starter_pkg::MON0_LOCKOUT] <= lockout_busy;
            mon_byte0[motor_starter_pkg::MON0_RUN_REV] <=
               (state_ff == motor_starter_pkg::run_rev);
         end
         mon_byte1 <= {digital_in, 2'b00};
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_dir_interlock: assert property (is_rev && $past(is_rev)
      |-> !(relay_out_zero && relay_out_one))
      else $error("forward and reverse relays on together");
   a_ovl_fault_out: assert property (is_ovl && $past(is_ovl) && $past(fault_ff)
      |-> !relay_out_zero && relay_out_one)
      else $error("overload mode fault did not swap relays");
   a_fault_report: assert property (fault_ff |=> mon_byte0[6])
      else $error("summary fault not reported");
   a_reverse_block: assert property (state_ff == motor_starter_pkg::motor_off
      && last_dir_ff == motor_starter_pkg::run_fwd && lockout_busy
      |=> state_ff != motor_starter_pkg::run_rev)
      else $error("reverse start during lockout");
   a_same_restart: assert property (state_ff == motor_starter_pkg::motor_off
      && last_dir_ff == motor_starter_pkg::run_fwd && req_fwd && !req_off
      && !fault_ff && !overload_trip && !cb_fault && !is_ovl
      |=> state_ff == motor_starter_pkg::run_fwd)
      else $error("same direction restart delayed");
   a_no_direct_flip: assert property (state_ff == motor_starter_pkg::run_fwd
      |=> state_ff != motor_starter_pkg::run_rev)
      else $error("direction changed without off");
   a_fault_release: assert property (fault_ff && !overload_trip && !cb_fault
      && reset_edge |=> !fault_ff ##1 !mon_byte0[6])
      else $error("fault reset not honoured");
   a_fault_output: assert property (fault_on_dc && fault_ff && $past(fault_on_dc)
      |=> dc_supply_output)
      else $error("fault output not driven");
   a_input_mirror: assert property (1'b1 |=> mon_byte1[7:2] == $past(digital_in))
      else $error("inputs not mirrored");

   c_run_reverse: cover property (state_ff == motor_starter_pkg::run_rev);
   c_lockout_reject: cover property (state_ff == motor_starter_pkg::motor_off
      && lockout_busy && req_rev && last_dir_ff == motor_starter_pkg::run_fwd);
   c_fault_cleared: cover property (fault_ff ##1 !fault_ff);

endmodule

// file: rtl/motor_starter_pkg.sv
// constants shared by the motor starter control logic
// assumes a 50 MHz system clock and fieldbus bytes held stable by the bus interface
package motor_starter_pkg;

   // control function selection
   typedef enum logic [1:0]
   {
      overload_relay_mode    = 2'h0,
      direct_starter_mode    = 2'h1,
      reversing_starter_mode = 2'h2
   } ctrl_mode_t;

   // fault output placement
   typedef enum logic [1:0]
   {
      fault_out_none      = 2'h0,
      fault_out_relay_two = 2'h1,
      fault_out_dc_supply = 2'h2
   } fault_out_sel_t;

   // motor run states
   typedef enum logic [1:0]
   {
      motor_off = 2'h0,
      run_fwd   = 2'h1,
      run_rev   = 2'h2
   } run_state_t;

   // command byte 0 bit positions
   localparam int unsigned CMD0_RUN_REV      = 0;
   localparam int unsigned CMD0_OFF          = 1;
   localparam int unsigned CMD0_RUN_FWD      = 2;
   localparam int unsigned CMD0_PREP_EMERG   = 4;
   localparam int unsigned CMD0_AUTO_MODE    = 5;
   localparam int unsigned CMD0_FAULT_RESET  = 6;
   // command byte 1 bit positions
   localparam int unsigned CMD1_DC_SUPPLY    = 4;
   localparam int unsigned CMD1_RELAY_ONE    = 6;
   localparam int unsigned CMD1_RELAY_TWO    = 7;
   // monitoring byte 0 bit positions
   localparam int unsigned MON0_RUN_REV      = 0;
   localparam int unsigned MON0_OFF          = 1;
   localparam int unsigned MON0_RUN_FWD      = 2;
   localparam int unsigned MON0_OVL_WARN     = 3;
   localparam int unsigned MON0_LOCKOUT      = 4;
   localparam int unsigned MON0_LOCAL        = 5;
   localparam int unsigned MON0_SUM_FAULT    = 6;
   localparam int unsigned MON0_SUM_WARN     = 7;
   // monitoring byte 1: inputs five..zero land at bits 7..2
   localparam int unsigned MON1_INPUT_LSB    = 2;

   // reset values
   localparam logic [7:0]  MON_RESET         = 8'h00;
   localparam logic        RELAY_RESET       = 1'b0;

   // timing
   localparam int unsigned CLOCK_NS          = 20;
   localparam int unsigned TICK_NS           = 1000000;   // lockout time unit: 1 ms
   localparam int unsigned TICK_CYCLES       = TICK_NS / CLOCK_NS;
   localparam int unsigned CHECKBACK_MS      = 100;       // contactor feedback window
   localparam int unsigned LOCKOUT_WIDTH     = 16;

endpackage

// file: rtl/reverse_lockout_timer.sv
// millisecond tick and reverse lockout countdown
// assumes off_pulse is one cycle wide when the motor leaves a run state
`timescale 1ns/100ps
module reverse_lockout_timer
#(
   parameter int unsigned TICK_CYCLES = motor_starter_pkg::TICK_CYCLES,
   parameter int unsigned LOCK_WIDTH  = motor_starter_pkg::LOCKOUT_WIDTH
)
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   // control
   input  wire logic                  off_pulse,
   input  wire logic [LOCK_WIDTH-1:0] lockout_ms,
   // status
   output logic                       ms_tick,
   output logic                       lockout_busy
);

   logic [31:0]           tick_cnt_ff;
   logic [LOCK_WIDTH-1:0] lock_cnt_ff;

   initial
   begin
      if (TICK_CYCLES < 1 || LOCK_WIDTH < 1 || LOCK_WIDTH > 31)
         $error("reverse_lockout_timer: unsupported parameters");
   end

   // free running millisecond prescaler
   always_ff @(posedge clock)
   begin
      if (sys_rst || tick_cnt_ff == 32'(TICK_CYCLES - 1))
         tick_cnt_ff <= 32'h0;
      else
         tick_cnt_ff <= tick_cnt_ff + 32'h1;
   end

   assign ms_tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

   // restart on every switch-off; a running count is not extended by ticks
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         lock_cnt_ff <= '0;
      else if (off_pulse)
         lock_cnt_ff <= lockout_ms;
      else if (ms_tick && lock_cnt_ff != '0)
         lock_cnt_ff <= lock_cnt_ff - 1'b1;
   end

   assign lockout_busy = (lock_cnt_ff != '0);

endmodule

// file: testbench/contactor_model.sv
// contactor model: auxiliary contact follows the coils two cycles late
// assumes relay outputs change on the rising clock edge
`timescale 1ns/100ps
module contactor_model
(
   // clock
   input  wire logic clock,
   // coil drive and fault injection
   input  wire logic coil_fwd,
   input  wire logic coil_rev,
   input  wire logic stuck_open,
   // auxiliary contact, open reads low
   output logic      aux_closed
);
   logic [1:0] pull_in_ff;

   // armature lag, so checkback sees a short mismatch on every switch
   always_ff @(posedge clock)
   begin
      pull_in_ff <= {pull_in_ff[0], coil_fwd | coil_rev};
   end

   // a welded-open contact never reports closed
   assign aux_closed = pull_in_ff[1] & ~stuck_open;
endmodule

// file: testbench/tb_motor_starter_control.sv
// self-checking bench for the motor starter control block
// assumes short tick and checkback parameters; inputs change on falling edges
`timescale 1ns/100ps
module tb_motor_starter_control;
   typedef struct packed
   {
      logic [1:0] mode;
      logic [1:0] fsel;
      logic [7:0] c0;
      logic [7:0] c1;
      logic [5:0] din;
      logic       warn;
      logic [7:0] m0;
      logic [7:0] m1;
      logic [7:0] outs;
   } row_t;

   logic        clock              = 1'b0;
   logic        sys_rst            = 1'b1;
   logic [1:0]  ctrl_mode          = 2'h0;
   logic [1:0]  fault_out_sel      = 2'h0;
   logic        local_start_en     = 1'b0;
   logic        checkback_en       = 1'b0;
   logic [15:0] reverse_lockout_ms = 16'h0005;
   logic [7:0]  cmd_byte0          = 8'h00;
   logic [7:0]  cmd_byte1          = 8'h00;
   logic        overload_trip      = 1'b0;
   logic        overload_warn      = 1'b0;
   logic [5:0]  din                = 6'h00;
   logic        use_model          = 1'b0;
   logic        stuck_open         = 1'b0;
   logic [7:0]  mon_byte0;
   logic [7:0]  mon_byte1;
   logic        relay_out_zero;
   logic        relay_out_one;
   logic        relay_out_two;
   logic        dc_supply_output;
   logic        emerg_start_prep;
   logic        aux_closed;
   int          fail_count         = 0;
   int          comparisons        = 0;
   int          cycle_count        = 0;
   wire logic [5:0] digital_in = {din[5:1], use_model ? aux_closed : din[0]};
   // outputs packed as {zero, one, two, dc, emergency prepare}
   wire logic [7:0] outs = {3'h0, relay_out_zero, relay_out_one, relay_out_two,
                            dc_supply_output, emerg_start_prep};

   // inputs, config and expected monitoring bytes and outputs
   row_t rows [6] = '{
      '{2'h0, 2'h0, 8'h00, 8'h90, 6'h2a, 1'b0, 8'h00, 8'ha8, 8'h16},
      '{2'h0, 2'h0, 8'h10, 8'h00, 6'h15, 1'b1, 8'h88, 8'h54, 8'h11},
      '{2'h0, 2'h1, 8'h00, 8'h80, 6'h00, 1'b0, 8'h00, 8'h00, 8'h10},
      '{2'h1, 2'h2, 8'h02, 8'hd0, 6'h3f, 1'b0, 8'h22, 8'hfc, 8'h0c},
      '{2'h1, 2'h0, 8'h22, 8'h10, 6'h00, 1'b1, 8'h8a, 8'h00, 8'h02},
      '{2'h2, 2'h1, 8'h22, 8'h80, 6'h01, 1'b0, 8'h02, 8'h04, 8'h00}
   };

   motor_starter_control #(.TICK_CYCLES(4), .CHECKBACK_MS(3)) motor_starter_control_i
   (
      .clock              (clock),
      .sys_rst            (sys_rst),
      .ctrl_mode          (ctrl_mode),
      .fault_out_sel      (fault_out_sel),
      .local_start_en     (local_start_en),
      .checkback_en       (checkback_en),
      .reverse_lockout_ms (reverse_lockout_ms),
      .cmd_byte0          (cmd_byte0),
      .cmd_byte1          (cmd_byte1),
      .mon_byte0          (mon_byte0),
      .mon_byte1          (mon_byte1),
      .overload_trip      (overload_trip),
      .overload_warn      (overload_warn),
      .digital_in         (digital_in),
      .relay_out_zero     (relay_out_zero),
      .relay_out_one      (relay_out_one),
      .relay_out_two      (relay_out_two),
      .dc_supply_output   (dc_supply_output),
      .emerg_start_prep   (emerg_start_prep)
   );

   contactor_model contactor_model_i
   (
      .clock      (clock),
      .coil_fwd   (relay_out_zero),
      .coil_rev   (relay_out_one),
      .stuck_open (stuck_open),
      .aux_closed (aux_closed)
   );

   // 20 ns period
   always #10 clock = ~clock;

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // master writes command byte 0, then some cycles pass
   task automatic cmd(input logic [7:0] c0, input int n);
      cmd_byte0 = c0;
      cyc(n);
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (fail_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard, plus both directions energised is never allowed
   always @(negedge clock)
   begin
      cycle_count++;
      if ((ctrl_mode === 2'h2) && ((relay_out_zero & relay_out_one) === 1'b1))
         chk(8'h01, 8'h00);
      if (cycle_count == 3000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   initial
   begin
      cyc(3);
      chk(outs, 8'h00);
      chk(mon_byte0, 8'h00);
      cyc(1);
      sys_rst = 1'b0;
      cyc(2);
      chk(outs, 8'h10);
      // static bit mapping rows, bits only as the master may write them
      foreach (rows[i])
      begin
         ctrl_mode = rows[i].mode;
         fault_out_sel = rows[i].fsel;
         cmd_byte0 = rows[i].c0;
         cmd_byte1 = rows[i].c1;
         din = rows[i].din;
         overload_warn = rows[i].warn;
         cyc(3);
         chk(mon_byte0, rows[i].m0);
         chk(mon_byte1, rows[i].m1);
         chk(outs, rows[i].outs);
      end
      // reset in mid-run drops everything, overload relay closes again
      {ctrl_mode, fault_out_sel, cmd_byte0, cmd_byte1, din, overload_warn} = '0;
      sys_rst = 1'b1;
      cyc(2);
      chk(outs, 8'h00);
      sys_rst = 1'b0;
      cyc(2);
      chk(outs, 8'h10);
      // overload trip with dc output as fault output; reset refused while tripped
      fault_out_sel = 2'h2;
      overload_trip = 1'b1;
      cyc(3);
      chk(outs, 8'h0a);
      chk(mon_byte0, 8'h40);
      cmd(8'h40, 3);
      chk(mon_byte0, 8'h40);
      overload_trip = 1'b0;
      cmd(8'h00, 1);
      cmd(8'h40, 3);
      chk(mon_byte0, 8'h00);
      chk(outs, 8'h10);
      // direct starter by bus with a healthy checkback contact
      ctrl_mode = 2'h1;
      fault_out_sel = 2'h1;
      checkback_en = 1'b1;
      use_model = 1'b1;
      cmd(8'h20, 2);
      cmd(8'h24, 3);
      chk(outs, 8'h10);
      chk(mon_byte0, 8'h04);
      cyc(30);
      chk(mon_byte0, 8'h04);
      cmd_byte1 = 8'h40;
      cyc(2);
      chk(outs, 8'h18);
      cmd_byte1 = 8'h00;
      cmd(8'h22, 3);
      chk(outs, 8'h00);
      chk(mon_byte0, 8'h02);
      // local buttons: four starts, five stops
      cmd(8'h00, 1);
      local_start_en = 1'b1;
      din = 6'h10;
      cyc(3);
      chk(outs, 8'h10);
      chk(mon_byte0, 8'h24);
      din = 6'h20;
      cyc(3);
      chk(outs, 8'h00);
      din = 6'h00;
      local_start_en = 1'b0;
      // contact never closes: checkback fault, relay two as fault output
      stuck_open = 1'b1;
      cmd(8'h20, 1);
      cmd(8'h24, 40);
      chk(outs, 8'h04);
      chk(mon_byte0 & 8'h40, 8'h40);
      stuck_open = 1'b0;
      cmd(8'h20, 1);
      cmd(8'h60, 3);
      chk(outs, 8'h00);
      cmd(8'h21, 3);
      chk(outs, 8'h00);
      // reversing starter and its lockout
      ctrl_mode = 2'h2;
      fault_out_sel = 2'h0;
      checkback_en = 1'b0;
      use_model = 1'b0;
      cmd(8'h20, 40);
      cmd(8'h24, 3);
      chk(outs, 8'h10);
      cmd(8'h25, 3);
      chk(outs, 8'h10);
      cmd(8'h22, 3);
      chk(outs, 8'h00);
      chk(mon_byte0, 8'h12);
      cmd(8'h20, 1);
      cmd(8'h21, 3);
      chk(outs, 8'h00);
      cmd(8'h20, 1);
      cmd(8'h24, 3);
      chk(outs, 8'h10);
      cmd(8'h22, 40);
      chk(mon_byte0, 8'h02);
      cmd(8'h20, 1);
      cmd(8'h21, 3);
      chk(outs, 8'h08);
      // local stop on five, local reverse start on three
      cmd(8'h00, 1);
      local_start_en = 1'b1;
      din = 6'h20;
      cyc(3);
      chk(outs, 8'h00);
      din = 6'h00;
      cyc(40);
      din = 6'h08;
      cyc(3);
      chk(outs, 8'h08);
      // unused mode code holds the motor off
      ctrl_mode = 2'h3;
      cyc(3);
      chk(outs, 8'h00);
      chk(mon_byte0, 8'h22);
      tally_and_finish();
   end
endmodule
